// ==== rtl/pucr_core.sv ====
/*
 * Power stage update, fractional resolution and retrigger core.
 * Assumes synchronous trigger and comparator inputs and an Avalon-MM master
 * that holds its request until waitrequest is low.
 */
`timescale 1ns/100ps

module pucr_core
	import pucr_pkg::*;
(
	input  wire logic        clk_sys_in,
	input  wire logic        reset_n_in,
	input  wire logic [5:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic      [31:0] avs_readdata_out,
	output logic             avs_waitrequest_out,
	input  wire logic        external_trigger_pin_in,
	input  wire logic        comparator_a_in,
	input  wire logic        comparator_b_in,
	output logic             drive_out_a_out,
	output logic             drive_out_b_out
);

	// ----------------------------------------------------------------
	// Phase machine
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		PH_DT0 = 4'b0001,
		PH_OT0 = 4'b0010,
		PH_DT1 = 4'b0100,
		PH_OT1 = 4'b1000
	} pucr_phase_type;

	// Lengthened-cycle pattern: bit-reverse of position below d
	function automatic logic frac_hit(input logic [3:0] pos, input logic [3:0] d);
		logic [3:0] rev;
		rev = {pos[0], pos[1], pos[2], pos[3]};
		frac_hit = (rev < d);
	endfunction : frac_hit

	function automatic logic [CMP_W-1:0] merge(input logic [CMP_W-1:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction : merge

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic           run_reg;
	logic           hold_reg;
	logic           auto_req_reg;
	logic           auto_act_reg;
	logic           enh_reg;
	pucr_ramp_type  ramp_reg;
	pucr_set_type   pend_reg;
	pucr_set_type   work_reg;
	pucr_inctl_type inctl_a_reg;
	pucr_inctl_type inctl_b_reg;
	logic           rb_last_reg;
	logic           dirty_reg;
	logic           wait_reg;
	logic [31:0]    rdata_reg;
	pucr_phase_type phase_reg;
	logic [12:0]    cnt_reg;
	logic [3:0]     frame_reg;
	logic [3:0]     frac_reg;
	logic           in_a_prev_reg;
	logic           in_b_prev_reg;
	logic           out_a_reg;
	logic           out_b_reg;
	logic           run_prev_reg;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	wire logic access    = (avs_read_in | avs_write_in) & wait_reg;
	wire logic wr_take   = avs_write_in & ~wait_reg;
	wire logic rd_take   = avs_read_in & ~wait_reg;
	wire logic sel_ctl   = avs_address_in == OFS_CONTROL;
	wire logic sel_sa    = avs_address_in == OFS_SET_A;
	wire logic sel_ra    = avs_address_in == OFS_RESET_A;
	wire logic sel_sb    = avs_address_in == OFS_SET_B;
	wire logic sel_rb    = avs_address_in == OFS_RESET_B;
	wire logic sel_oc    = avs_address_in == OFS_OUT_CFG;
	wire logic sel_mx    = avs_address_in == OFS_MATRIX;
	wire logic sel_ia    = avs_address_in == OFS_INPUT_A;
	wire logic sel_ib    = avs_address_in == OFS_INPUT_B;
	wire logic sel_st    = avs_address_in == OFS_STATUS;
	wire logic wr_ctl    = wr_take & sel_ctl & avs_byteenable_in[0];

	// Timing values from the working set
	wire logic [11:0] ot0 = work_reg.reset_a[CNT_W-1:0];
	wire logic [11:0] dt0 = work_reg.set_a[CNT_W-1:0];
	wire logic [11:0] ot1 = work_reg.reset_b[CNT_W-1:0];
	wire logic [11:0] dt1 = work_reg.set_b[CNT_W-1:0];

	// ----------------------------------------------------------------
	// Input units
	// ----------------------------------------------------------------
	// input A source select
	wire logic raw_a   = inctl_a_reg.src_pin ? external_trigger_pin_in : comparator_a_in;
	wire logic raw_b   = inctl_b_reg.src_pin ? external_trigger_pin_in : comparator_b_in;
	wire logic lvl_a   = raw_a ~^ inctl_a_reg.pol_high;
	wire logic lvl_b   = raw_b ~^ inctl_b_reg.pol_high;
	wire logic edge_a  = (inctl_a_reg.mode == INMODE_EDGE) & lvl_a & ~in_a_prev_reg;
	wire logic edge_b  = (inctl_b_reg.mode == INMODE_EDGE) & lvl_b & ~in_b_prev_reg;
	wire logic level_a = (inctl_a_reg.mode == INMODE_LEVEL) & lvl_a;
	wire logic level_b = (inctl_b_reg.mode == INMODE_LEVEL) & lvl_b;
	wire logic in_a_phase = (phase_reg == PH_DT0) | (phase_reg == PH_OT0);
	wire logic in_b_phase = (phase_reg == PH_DT1) | (phase_reg == PH_OT1);
	wire logic one_ramp   = ramp_reg == RAMP_ONE;
	wire logic trig_ok    = run_reg & (ramp_reg != RAMP_CENTER);
	wire logic trig_a     = trig_ok & (edge_a | level_a) & (in_a_phase | one_ramp);
	wire logic trig_b     = trig_ok & (edge_b | level_b) & (in_b_phase | one_ramp);

	// ----------------------------------------------------------------
	// Cycle sequencing
	// ----------------------------------------------------------------
	// extra count on part A
	wire logic       stretch   = enh_reg & frac_hit(frame_reg, frac_reg);
	wire logic [12:0] ot0_len  = {1'b0, ot0} + {12'h000, stretch};
	wire logic [12:0] cur_len  = (phase_reg == PH_DT0) ? {1'b0, dt0} :
	                             (phase_reg == PH_OT0) ? ot0_len :
	                             (phase_reg == PH_DT1) ? {1'b0, dt1} : {1'b0, ot1};
	wire logic       ph_done   = (cnt_reg + 13'h0001) >= cur_len;
	wire logic       cyc_end   = run_reg & ph_done & (phase_reg == PH_OT1);
	wire logic       commit_ok = auto_act_reg ? rb_last_reg : ~hold_reg;
	wire logic       start     = run_reg & ~run_prev_reg;
	wire logic       commit    = dirty_reg & commit_ok & (cyc_end | start | ~run_reg);

	pucr_phase_type phase_next;
	always_comb begin
		unique case (phase_reg)
			PH_DT0: phase_next = PH_OT0;
			PH_OT0: phase_next = PH_DT1;
			PH_DT1: phase_next = PH_OT1;
			PH_OT1: phase_next = PH_DT0;
			default: phase_next = PH_DT0;
		endcase
	end

	// ----------------------------------------------------------------
	// Bus slave: one wait cycle, then answer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wait_reg <= 1'b1;
		end else begin
			wait_reg <= ~access;
		end
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rdata_reg <= UNMAPPED_READ;
		end else if (rd_take) begin
			rdata_reg <= UNMAPPED_READ;
		end else if (access & avs_read_in) begin
			rdata_reg <= sel_ctl ? {24'h000000, 2'b00, ramp_reg, enh_reg, auto_req_reg,
			                        hold_reg, run_reg} :
			             sel_sa  ? {16'h0000, pend_reg.set_a} :
			             sel_ra  ? {16'h0000, pend_reg.reset_a} :
			             sel_sb  ? {16'h0000, pend_reg.set_b} :
			             sel_rb  ? {16'h0000, pend_reg.reset_b} :
			             sel_oc  ? {24'h000000, pend_reg.out_cfg} :
			             sel_mx  ? {24'h000000, pend_reg.matrix} :
			             sel_ia  ? {26'h0000000, inctl_a_reg} :
			             sel_ib  ? {26'h0000000, inctl_b_reg} :
			             sel_st  ? {20'h00000, frame_reg, phase_reg, 1'b0, auto_act_reg,
			                        rb_last_reg, dirty_reg} : UNMAPPED_READ;
		end
	end

	// ----------------------------------------------------------------
	// Control and pending registers
	// ----------------------------------------------------------------
	// software loads pending set
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			run_reg      <= 1'b0;
			hold_reg     <= 1'b0;
			auto_req_reg <= 1'b0;
			enh_reg      <= 1'b0;
			ramp_reg     <= RAMP_ONE;
			pend_reg     <= '{CMP_RESET, CMP_RESET, CMP_RESET, CMP_RESET, CFG_RESET, CFG_RESET};
			inctl_a_reg  <= '0;
			inctl_b_reg  <= '0;
		end else if (wr_take) begin
			if (wr_ctl) begin
				run_reg      <= avs_writedata_in[CTL_RUN_BIT];
				hold_reg     <= avs_writedata_in[CTL_HOLD_BIT];
				auto_req_reg <= avs_writedata_in[CTL_AUTO_BIT];
				enh_reg      <= avs_writedata_in[CTL_ENH_BIT];
				ramp_reg     <= pucr_ramp_type'(avs_writedata_in[CTL_MODE_LSB +: CTL_MODE_W]);
			end
			if (sel_sa) pend_reg.set_a   <= merge(pend_reg.set_a, avs_writedata_in, avs_byteenable_in);
			if (sel_ra) pend_reg.reset_a <= merge(pend_reg.reset_a, avs_writedata_in, avs_byteenable_in);
			if (sel_sb) pend_reg.set_b   <= merge(pend_reg.set_b, avs_writedata_in, avs_byteenable_in);
			if (sel_rb) pend_reg.reset_b <= merge(pend_reg.reset_b, avs_writedata_in, avs_byteenable_in);
			if (sel_oc & avs_byteenable_in[0]) pend_reg.out_cfg <= avs_writedata_in[7:0];
			if (sel_mx & avs_byteenable_in[0]) pend_reg.matrix  <= avs_writedata_in[7:0];
			if (sel_ia & avs_byteenable_in[0]) inctl_a_reg <= avs_writedata_in[5:0];
			if (sel_ib & avs_byteenable_in[0]) inctl_b_reg <= avs_writedata_in[5:0];
		end
	end

	// Write-tracking: a new write wins over a same-cycle commit
	wire logic wr_pend = wr_take & (sel_sa | sel_ra | sel_sb | sel_rb | sel_oc | sel_mx);

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			dirty_reg   <= 1'b0;
			rb_last_reg <= 1'b0;
		end else begin
			dirty_reg   <= wr_pend | (dirty_reg & ~commit);
			rb_last_reg <= wr_pend ? sel_rb : (rb_last_reg & ~commit);
		end
	end

	// ----------------------------------------------------------------
	// Working set, auto-commit latch, frame counter
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			work_reg     <= '{CMP_RESET, CMP_RESET, CMP_RESET, CMP_RESET, CFG_RESET, CFG_RESET};
			auto_act_reg <= 1'b0;
			frame_reg    <= 4'h0;
			frac_reg     <= 4'h0;
			run_prev_reg <= 1'b0;
		end else begin
			run_prev_reg <= run_reg;
			if (commit) begin
				work_reg <= pend_reg;
				frac_reg <= pend_reg.reset_b[CMP_W-1 -: FRAC_W];
			end
			if (cyc_end | ~run_reg) auto_act_reg <= auto_req_reg;
			if (~run_reg) frame_reg <= 4'h0;
			else if (cyc_end) frame_reg <= frame_reg + 4'h1;
		end
	end

	// ----------------------------------------------------------------
	// Counter, phases and outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			phase_reg     <= PH_DT0;
			cnt_reg       <= 13'h0000;
			in_a_prev_reg <= 1'b0;
			in_b_prev_reg <= 1'b0;
		end else begin
			in_a_prev_reg <= lvl_a;
			in_b_prev_reg <= lvl_b;
			if (~run_reg | start) begin
				phase_reg <= PH_DT0;
				cnt_reg   <= 13'h0000;
			end else if (one_ramp & (trig_a | trig_b)) begin
				phase_reg <= PH_DT0;
				cnt_reg   <= 13'h0000;
			end else if ((trig_a & in_a_phase) | (trig_b & in_b_phase)) begin
				phase_reg <= in_a_phase ? PH_DT1 : PH_DT0;
				cnt_reg   <= 13'h0000;
			end else if (ph_done) begin
				phase_reg <= phase_next;
				cnt_reg   <= 13'h0000;
			end else begin
				cnt_reg <= cnt_reg + 13'h0001;
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			out_a_reg <= 1'b0;
			out_b_reg <= 1'b0;
		end else begin
			out_a_reg <= run_reg & (phase_next == PH_OT0) & ph_done & ~trig_a & ~start;
			out_b_reg <= run_reg & (phase_next == PH_OT1) & ph_done & ~trig_b & ~start;
			if (run_reg & ~ph_done & ~start) begin
				out_a_reg <= (phase_reg == PH_OT0) & ~trig_a;
				out_b_reg <= (phase_reg == PH_OT1) & ~trig_b;
			end
		end
	end

	assign avs_readdata_out    = rdata_reg;
	assign avs_waitrequest_out = wait_reg;
	assign drive_out_a_out     = out_a_reg;
	assign drive_out_b_out     = out_b_reg;

endmodule : pucr_core

// ==== rtl/pucr_pkg.sv ====
/*
 * Package for the power stage update, fractional and retrigger block:
 * register map, field positions, reset values, mode codes, carrier types.
 * Assumes a 32-bit Avalon-MM slave port with word addresses in bytes.
 */
package pucr_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [5:0] OFS_CONTROL  = 6'h00;
	localparam logic [5:0] OFS_SET_A    = 6'h04;
	localparam logic [5:0] OFS_RESET_A  = 6'h08;
	localparam logic [5:0] OFS_SET_B    = 6'h0C;
	localparam logic [5:0] OFS_RESET_B  = 6'h10;
	localparam logic [5:0] OFS_OUT_CFG  = 6'h14;
	localparam logic [5:0] OFS_MATRIX   = 6'h18;
	localparam logic [5:0] OFS_INPUT_A  = 6'h1C;
	localparam logic [5:0] OFS_INPUT_B  = 6'h20;
	localparam logic [5:0] OFS_STATUS   = 6'h24;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int CTL_RUN_BIT     = 0;
	localparam int CTL_HOLD_BIT    = 1;
	localparam int CTL_AUTO_BIT    = 2;
	localparam int CTL_ENH_BIT     = 3;
	localparam int CTL_MODE_LSB    = 4;
	localparam int CTL_MODE_W      = 2;

	// ----------------------------------------------------------------
	// Input control register fields
	// ----------------------------------------------------------------
	localparam int INP_MODE_LSB    = 0;
	localparam int INP_MODE_W      = 4;
	localparam int INP_POL_BIT     = 4;
	localparam int INP_SRC_BIT     = 5;

	// ----------------------------------------------------------------
	// Widths and reset values
	// ----------------------------------------------------------------
	localparam int CNT_W           = 12;
	localparam int FRAC_W          = 4;
	localparam int CMP_W           = 16;
	localparam int CFG_W           = 8;
	localparam logic [CMP_W-1:0] CMP_RESET = 16'h0000;
	localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;
	localparam logic [31:0] UNMAPPED_READ  = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Input mode codes
	// ----------------------------------------------------------------
	localparam logic [3:0] INMODE_NONE  = 4'h0;
	localparam logic [3:0] INMODE_LEVEL = 4'h1;
	localparam logic [3:0] INMODE_EDGE  = 4'h8;

	// Ramp modes
	typedef enum logic [1:0] {
		RAMP_ONE    = 2'h0,
		RAMP_TWO    = 2'h1,
		RAMP_FOUR   = 2'h2,
		RAMP_CENTER = 2'h3
	} pucr_ramp_type;

	// One working or pending value set
	typedef struct packed {
		logic [CMP_W-1:0] set_a;
		logic [CMP_W-1:0] reset_a;
		logic [CMP_W-1:0] set_b;
		logic [CMP_W-1:0] reset_b;
		logic [CFG_W-1:0] out_cfg;
		logic [CFG_W-1:0] matrix;
	} pucr_set_type;

	// Input control value
	typedef struct packed {
		logic             src_pin;
		logic             pol_high;
		logic [3:0]       mode;
	} pucr_inctl_type;

endpackage : pucr_pkg

// ==== test/pucr_core_asserts.sv ====
/* Checker for the update core: bus handshake, readback and drive outputs.
   Assumes it is bound to pucr_core and sees only its ports. */
`timescale 1ns/100ps

module pucr_core_asserts
	import pucr_pkg::*;
(
	input wire logic        clk_sys_in,
	input wire logic        reset_n_in,
	input wire logic [5:0]  avs_address_in,
	input wire logic        avs_read_in,
	input wire logic        avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0]  avs_byteenable_in,
	input wire logic [31:0] avs_readdata_out,
	input wire logic        avs_waitrequest_out,
	input wire logic        external_trigger_pin_in,
	input wire logic        comparator_a_in,
	input wire logic        comparator_b_in,
	input wire logic        drive_out_a_out,
	input wire logic        drive_out_b_out
);
	// ----------------------------------------------------------------
	// Control shadow and stop counter
	// ----------------------------------------------------------------
	logic [5:0] ctl_reg;
	logic [1:0] stop_reg;
	wire        req      = avs_read_in || avs_write_in;
	wire        done     = !avs_waitrequest_out;
	wire        unmapped = (avs_address_in[1:0] != 2'h0) || (avs_address_in > OFS_STATUS);
	wire        ctl_take = done && avs_write_in && avs_address_in == OFS_CONTROL
		&& avs_byteenable_in[0];
	wire [5:0]  ctl_next  = ctl_take ? avs_writedata_in[5:0] : ctl_reg;
	wire [1:0]  stop_next = ctl_reg[CTL_RUN_BIT] ? 2'h0 : (&stop_reg ? 2'h3 : stop_reg + 2'h1);
	wire        two_four  = ctl_reg[5:4] == RAMP_TWO || ctl_reg[5:4] == RAMP_FOUR;

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ctl_reg  <= 6'h00;
			stop_reg <= 2'h0;
		end else begin
			ctl_reg  <= ctl_next;
			stop_reg <= stop_next;
		end
	end

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!reset_n_in);

	a_wait_pulse: assert property (done |=> !done)
		else $error("waitrequest low two cycles");
	a_wait_cause: assert property ($fell(avs_waitrequest_out) |-> $past(req))
		else $error("waitrequest low without request");
	a_answer_time: assert property (req && !done |=> done)
		else $error("request not answered next cycle");
	a_rdata_hold: assert property (!req && !done |=> $stable(avs_readdata_out))
		else $error("readdata changed while idle");
	a_unmapped_zero: assert property (avs_read_in && done && unmapped |-> avs_readdata_out == UNMAPPED_READ)
		else $error("unmapped read not zero");
	a_ctl_readback: assert property (avs_read_in && done && avs_address_in == OFS_CONTROL |-> avs_readdata_out[5:0] == ctl_reg)
		else $error("control readback differs");
	a_stop_idle: assert property (stop_reg == 2'h3 |-> !drive_out_a_out && !drive_out_b_out)
		else $error("drive active while stopped");
	a_no_overlap: assert property (two_four |-> !(drive_out_a_out && drive_out_b_out))
		else $error("both drives active");
endmodule : pucr_core_asserts

bind pucr_core pucr_core_asserts pucr_core_asserts_inst (
	.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .avs_address_in(avs_address_in),
	.avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
	.avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
	.avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
	.external_trigger_pin_in(external_trigger_pin_in), .comparator_a_in(comparator_a_in),
	.comparator_b_in(comparator_b_in), .drive_out_a_out(drive_out_a_out),
	.drive_out_b_out(drive_out_b_out));

// ==== test/pucr_load_model.sv ====
/* Far-side model: times the two drives, drives trigger and comparator lines.
   Assumes the core clock; lines follow bench levels one cycle later. */
`timescale 1ns/100ps

module pucr_load_model (
	input  wire logic        clk_sys_in,
	input  wire logic        reset_n_in,
	input  wire logic        drive_out_a_in,
	input  wire logic        drive_out_b_in,
	input  wire logic        clr_in,
	input  wire logic [3:0]  lvl_in,
	output logic      [2:0]  line_out,
	output logic      [31:0] rise_count_out,
	output logic      [31:0] period_out,
	output logic      [31:0] period_min_out,
	output logic      [31:0] hi_a_min_out,
	output logic      [31:0] hi_b_min_out,
	output logic      [31:0] part_b_out
);
	// ----------------------------------------------------------------
	// Edge timing
	// ----------------------------------------------------------------
	logic [31:0] cyc_reg, rise_a_reg, rise_b_reg, fall_a_reg;
	logic        a_reg, b_reg;
	wire  [31:0] since_a  = cyc_reg - rise_a_reg;
	wire  [31:0] since_b  = cyc_reg - rise_b_reg;
	wire  [31:0] since_fa = cyc_reg - fall_a_reg;

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			{cyc_reg, rise_a_reg, rise_b_reg, fall_a_reg, rise_count_out} <= '0;
			{a_reg, b_reg, line_out, period_out, part_b_out} <= '0;
			{period_min_out, hi_a_min_out, hi_b_min_out} <= '1;
		end else begin
			cyc_reg  <= cyc_reg + 32'h1;
			a_reg    <= drive_out_a_in;
			b_reg    <= drive_out_b_in;
			line_out <= lvl_in[2:0];
			if (clr_in)
				{period_min_out, hi_a_min_out, hi_b_min_out} <= '1;
			if (drive_out_a_in && !a_reg) begin
				rise_a_reg     <= cyc_reg;
				period_out     <= since_a;
				rise_count_out <= rise_count_out + 32'h1;
				if (!clr_in && since_a < period_min_out)
					period_min_out <= since_a;
			end
			if (!drive_out_a_in && a_reg) begin
				fall_a_reg <= cyc_reg;
				if (!clr_in && since_a < hi_a_min_out)
					hi_a_min_out <= since_a;
			end
			if (drive_out_b_in && !b_reg)
				rise_b_reg <= cyc_reg;
			if (!drive_out_b_in && b_reg) begin
				part_b_out <= since_fa;
				if (!clr_in && since_b < hi_b_min_out)
					hi_b_min_out <= since_b;
			end
		end
	end
endmodule : pucr_load_model

// ==== test/tb_top.sv ====
/* Bench for the update core: bus tasks, commit, fraction and retrigger tests.
   Assumes pucr_core and the load model; the checker is bound separately. */
`timescale 1ns/100ps

module tb_top
	import pucr_pkg::*;
;
	logic        clk_sys_in = 1'b0;
	logic        reset_n_in = 1'b0;
	logic [5:0]  adr = 6'h00;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [3:0]  be = 4'h3;
	logic        clr = 1'b0;
	logic [3:0]  lvl = 4'h0;
	logic [2:0]  line;
	logic [31:0] q, rdv, rises_n, per, per_min, hi_a, hi_b, part_b, h;
	logic        wait_rq, out_a, out_b;
	int          fail_count = 0;
	int          cmp_count = 0;
	int          n;
	logic [3:0]  dl [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'hF};

	always #2.5 clk_sys_in = ~clk_sys_in;

	pucr_core pucr_core_inst (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
		.avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
		.avs_byteenable_in(be), .avs_readdata_out(q), .avs_waitrequest_out(wait_rq),
		.external_trigger_pin_in(line[0]), .comparator_a_in(line[1]),
		.comparator_b_in(line[2]), .drive_out_a_out(out_a), .drive_out_b_out(out_b));

	pucr_load_model pucr_load_model_inst (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
		.drive_out_a_in(out_a), .drive_out_b_in(out_b), .clr_in(clr), .lvl_in(lvl),
		.line_out(line), .rise_count_out(rises_n), .period_out(per),
		.period_min_out(per_min), .hi_a_min_out(hi_a), .hi_b_min_out(hi_b),
		.part_b_out(part_b));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One Avalon access; an edge passes first so strobes never toggle twice
	task automatic bus(input logic r, input logic [5:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_sys_in);
		adr <= a;
		wd  <= d;
		rd  <= r;
		wr  <= !r;
		do begin
			@(posedge clk_sys_in);
			k++;
		end while (wait_rq !== 1'b0 && k < 100);
		rdv = q;
		rd <= 1'b0;
		wr <= 1'b0;
		if (k == 100) check(32'h0, 32'h1);
	endtask : bus

	task automatic rises(input int m);
		logic [31:0] t;
		int k;
		t = rises_n + 32'(m);
		k = 0;
		while (rises_n !== t && k < 4000) begin
			@(posedge clk_sys_in);
			k++;
		end
		if (k == 4000) check(32'h0, 32'h1);
	endtask : rises

	task automatic trig(input int sel, input int dly);
		clr <= 1'b1;
		rises(1);
		clr <= 1'b0;
		repeat (dly) @(posedge clk_sys_in);
		lvl[sel] <= 1'b1;
		repeat (2) @(posedge clk_sys_in);
		lvl[sel] <= 1'b0;
		rises(2);
	endtask : trig

	task automatic summarize();
		if (fail_count == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : summarize

	initial begin
		#200000;
		check(32'h0, 32'h1);
		summarize();
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge clk_sys_in);
		reset_n_in <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			bus(1'b1, 6'(4 * i), 32'h0);
			check(rdv, 32'h0);
		end
		bus(1'b0, 6'h3C, 32'h1234);
		bus(1'b1, 6'h3C, 32'h0);
		check(rdv, UNMAPPED_READ);
		// All four timing values written by software before the run
		bus(1'b0, OFS_SET_A, 32'h3);
		bus(1'b0, OFS_RESET_A, 32'h5);
		bus(1'b0, OFS_SET_B, 32'h2);
		bus(1'b0, OFS_RESET_B, 32'h4);
		bus(1'b0, OFS_CONTROL, 32'h21);
		rises(3);
		check(per, 32'h0E);
		bus(1'b0, OFS_CONTROL, 32'h23);
		bus(1'b0, OFS_RESET_B, 32'h6);
		rises(3);
		check(per, 32'h0E);
		bus(1'b1, OFS_STATUS, 32'h0);
		check({31'h0, rdv[0]}, 32'h1);
		bus(1'b0, OFS_CONTROL, 32'h21);
		rises(3);
		check(per, 32'h10);
		bus(1'b0, OFS_CONTROL, 32'h27);
		rises(2);
		bus(1'b0, OFS_SET_A, 32'h4);
		bus(1'b1, OFS_STATUS, 32'h0);
		check({31'h0, rdv[1]}, 32'h0);
		rises(3);
		check(per, 32'h10);
		bus(1'b0, OFS_RESET_B, 32'h4);
		rises(3);
		check(per, 32'h0F);
		bus(1'b0, OFS_SET_A, 32'h3);
		bus(1'b0, OFS_RESET_B, 32'h4);
		bus(1'b0, OFS_CONTROL, 32'h29);
		for (int j = 0; j < 5; j++) begin
			bus(1'b0, OFS_RESET_B, {16'h0, dl[j], 12'h004});
			rises(3);
			n = 0;
			repeat (16) begin
				rises(1);
				check(32'(per == 32'h0E || per == 32'h0F), 32'h1);
				if (per == 32'h0F) n++;
			end
			check(32'(n), 32'(dl[j]));
			check(part_b, 32'h6);
		end
		bus(1'b0, OFS_RESET_B, 32'h4);
		bus(1'b0, OFS_INPUT_A, 32'h38);
		bus(1'b0, OFS_INPUT_B, 32'h18);
		bus(1'b0, OFS_CONTROL, 32'h11);
		rises(3);
		trig(3, 0);
		check(hi_a, 32'h5);
		check(hi_b, 32'h4);
		trig(0, 0);
		check(32'(hi_a < 32'h5), 32'h1);
		trig(2, 6);
		check(32'(hi_b < 32'h4), 32'h1);
		bus(1'b0, OFS_INPUT_A, 32'h30);
		trig(0, 0);
		check(hi_a, 32'h5);
		bus(1'b0, OFS_INPUT_A, 32'h18);
		trig(0, 0);
		check(hi_a, 32'h5);
		trig(1, 0);
		check(32'(hi_a < 32'h5), 32'h1);
		bus(1'b0, OFS_INPUT_A, 32'h31);
		trig(0, 0);
		check(32'(hi_a < 32'h5), 32'h1);
		bus(1'b0, OFS_INPUT_A, 32'h18);
		bus(1'b0, OFS_CONTROL, 32'h31);
		rises(3);
		trig(3, 0);
		h = hi_a;
		trig(1, 0);
		check(hi_a, h);
		bus(1'b0, OFS_CONTROL, 32'h01);
		rises(3);
		trig(3, 0);
		h = per_min;
		trig(1, 0);
		check(32'(per_min < h), 32'h1);
		bus(1'b0, OFS_CONTROL, 32'h00);
		bus(1'b0, OFS_RESET_A, 32'h6);
		repeat (20) @(posedge clk_sys_in);
		check({30'h0, out_a, out_b}, 32'h0);
		bus(1'b0, OFS_CONTROL, 32'h21);
		rises(3);
		check(per, 32'h0F);
		summarize();
	end
endmodule : tb_top
